/* dv/fss_fan_model.sv */
// Fan model: tach flags minimum speed after a lag
`timescale 1ns/100ps
module fss_fan #(parameter integer LAG = 20) (input wire clk, input wire [6:0] pct, output reg at_min = 1'b0);
  integer n = 0;
  always @(posedge clk) begin
    n <= (pct == 7'h00) ? 0 : n + 1;
    at_min <= n >= LAG;
  end
endmodule // fss_fan

/* dv/fss_top_assertions.sv */
// Port assertions for the fan spin-up sequencer
`timescale 1ns/100ps
module fss_chk #(parameter integer UNIT_CYCLES = 4) (input REF_CLK, RST_N, REG_RD, SPIN_ACTIVE,
  input [7:0] REG_RDATA, input [5:0] DUTY_CMD, DUTY_VALUE, input [6:0] SPIN_PCT);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  sequence s_end; ##[1:270] !SPIN_ACTIVE; endsequence
  a_rsv_zero:
    assert property (REG_RD |=> REG_RDATA[7:6] == 2'h0) else $error("reserved bits set");
  a_spin_duty0:
    assert property (SPIN_ACTIVE |-> DUTY_VALUE == 6'h00) else $error("duty during spin");
  a_pct_legal:
    assert property (SPIN_ACTIVE |-> SPIN_PCT inside {7'h32, 7'h4b, 7'h51, 7'h64}) else $error("bad pct");
  a_idle_pct:
    assert property (!SPIN_ACTIVE |-> SPIN_PCT == 7'h00) else $error("idle pct");
  a_pct_held:
    assert property (SPIN_ACTIVE |=> !SPIN_ACTIVE || $stable(SPIN_PCT)) else $error("pct moved");
  a_start_edge:
    assert property ($rose(SPIN_ACTIVE) |-> $past(DUTY_CMD, 2) == 6'h00 && $past(DUTY_CMD) != 6'h00) else $error("start");
  a_spin_bound:
    assert property ($rose(SPIN_ACTIVE) |-> s_end) else $error("spin too long");
  a_duty_pass:
    assert property (!SPIN_ACTIVE && $stable(DUTY_CMD) |-> DUTY_VALUE == DUTY_CMD) else $error("duty pass");
endmodule // fss_chk
bind fss_top fss_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (.REF_CLK, .RST_N, .REG_RD, .SPIN_ACTIVE,
  .REG_RDATA, .DUTY_CMD, .DUTY_VALUE, .SPIN_PCT);

/* dv/test_fan_fast_tach_start_enable_sequencer.sv */
// Directed bench for the fan spin-up sequencer
`timescale 1ns/100ps
module test_fan_fast_tach_start_enable_sequencer;
  reg clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, tme = 1'b0;
  reg [7:0] addr = 8'h00, wd = 8'h00;
  reg [5:0] cmd = 6'h00;
  reg [4:0] fsel = 5'h17;
  wire [5:0] dv;
  wire [7:0] rdata;
  wire act, tach;
  wire [6:0] pct;
  integer bad_count = 0, n_tests = 0, n;
  fss_top #(.UNIT_CYCLES(4)) uut (.REF_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .DUTY_CMD(cmd), .PWM_FREQ_SEL(fsel), .TACH_MODE_EN(tme),
    .TACH_AT_MIN(tach), .SPIN_ACTIVE(act), .SPIN_PCT(pct), .DUTY_VALUE(dv));
  fss_fan fan (.clk(clk), .pct(pct), .at_min(tach));
  initial forever #5 clk = ~clk;
  task ck(input [7:0] g, e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("mismatch %0t got %h want %h", $time, g, e);
      end
    end
  endtask
  task acc(input w, input [7:0] a, d);
    begin
      @(posedge clk) #1 addr = a;
      wd = d;
      wr = w;
      rd = !w;
      @(posedge clk) #1 wr = 1'b0;
      rd = 1'b0;
      if (!w) ck(rdata, d);
    end
  endtask
  task spin(input [7:0] c, input t, input [6:0] p, input [8:0] lo, hi);
    begin
      acc(1'b1, 8'h4b, c);
      tme = t;
      @(posedge clk) #1 cmd = 6'h05;
      @(posedge clk) #1 ck(pct, p);
      ck(dv, p ? 8'h00 : 8'h05);
      acc(1'b0, 8'h4c, p ? 8'h00 : 8'h05);
      n = 2;
      while (act && n < 300) @(posedge clk) #1 n = n + 1;
      ck(n >= lo && n <= hi, 8'h01);
      ck(dv, 8'h05);
      @(posedge clk) #1 cmd = 6'h00;
    end
  endtask
  task tally_and_finish;
    begin
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    acc(1'b0, 8'h4b, 8'h3f);
    acc(1'b1, 8'h4b, 8'hff);
    acc(1'b0, 8'h4b, 8'h3f);
    spin(8'h09, 1'b0, 7'h32, 3, 7);
    spin(8'h12, 1'b0, 7'h4b, 7, 11);
    spin(8'h19, 1'b0, 7'h64, 3, 7);
    fsel = 5'h03;
    spin(8'h11, 1'b0, 7'h51, 3, 7);
    acc(1'b0, 8'h4d, 8'h00);
    spin(8'h04, 1'b0, 7'h00, 2, 2);
    spin(8'h25, 1'b0, 7'h64, 63, 67);
    spin(8'h38, 1'b1, 7'h00, 2, 2);
    spin(8'h3f, 1'b1, 7'h64, 18, 28);
    tally_and_finish;
  end
  initial begin
    #20000 bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule // test_fan_fast_tach_start_enable_sequencer

/* src/fss_consts.vh */
// Register offsets, field layout, reset values and timing for the fan start sequencer
`ifndef FSS_CONSTS_VH
`define FSS_CONSTS_VH
`define FSS_START_CFG_ADDR 8'h4b
`define FSS_DUTY_VAL_ADDR 8'h4c
`define FSS_START_CFG_RST 6'h3f
`define FSS_FAST_BIT 5
`define FSS_DUTY_HI 4
`define FSS_DUTY_LO 3
`define FSS_TIME_HI 2
`define FSS_TIME_LO 0
`define FSS_DUTY_OFF 2'h0
`define FSS_DUTY_HALF 2'h1
`define FSS_DUTY_HIGH 2'h2
`define FSS_DUTY_FULL 2'h3
`define FSS_PCT_ZERO 7'h00
`define FSS_PCT_50 7'h32
`define FSS_PCT_75 7'h4b
`define FSS_PCT_81 7'h51
`define FSS_PCT_100 7'h64
`define FSS_FREQ_SPLIT 5'h08
`define FSS_CLK_MHZ 100
`define FSS_UNIT_MS 50
`define FSS_UNIT_CYC (`FSS_UNIT_MS * 1000 * `FSS_CLK_MHZ)
`endif

/* src/fss_timer.v */
// Spin-up interval timer counting 50 ms units
`timescale 1ns/100ps
module fss_timer #(
  parameter integer UNIT_CYCLES = 5000000
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire abort,
  input wire [2:0] time_code,
  output reg done
);
  reg [22:0] pre_r;
  reg [6:0] units_r;
  reg run_r;
  wire unit_tick;
  wire [6:0] unit_load;

  assign unit_tick = (pre_r == 23'h000000);
  // Code 1 is one unit, each step doubles
  assign unit_load = 7'h01 << (time_code - 3'h1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 23'h000000;
      units_r <= 7'h00;
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        run_r <= 1'b1;
        units_r <= unit_load;
        pre_r <= UNIT_CYCLES[22:0] - 23'h000001;
      end else if (abort) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        if (unit_tick) begin
          pre_r <= UNIT_CYCLES[22:0] - 23'h000001;
          if (units_r == 7'h01) begin
            run_r <= 1'b0;
            done <= 1'b1;
          end
          units_r <= units_r - 7'h01;
        end else begin
          pre_r <= pre_r - 23'h000001;
        end
      end
    end
  end
endmodule // fss_timer

/* src/fss_top.v */
// Fan spin-up sequencer: start configuration register and spin-up phase control
// Function
// (RL1) Configuration bits 7:6 always read back as zero.
// (RL2) Fast bit clear: spin-up uses programmed duty and time fields.
// (RL3) Fast bit set: drive full duty during spin-up.
// (RL4) Fast mode ends at timeout or tach reaching setpoint minimum, whichever first.
// (RL5) Fast bit set: duty field ignored, full duty used.
// (RL6) Time field zero skips spin-up regardless of fast bit.
// (RL7) Duty field zero skips spin-up unless fast bit set.
// (RL8) Duty codes: 01 50%, 10 75-81% by frequency, 11 100%.
// (RL9) Time codes 001..111 give 0.05 s doubling up to 3.2 s.
// (RL10) Software must enable tachometer mode for speed-terminated fast spin-up.
// (RL11) Reset value: fast enabled, duty code 11, time code 111.
// (RL12) Duty value register reads zero while spin-up runs.
// (RL13) Off-to-on duty command starts spin-up, then normal duty resumes.
`timescale 1ns/100ps
`include "fss_consts.vh"
module fss_top #(
  parameter integer UNIT_CYCLES = `FSS_UNIT_CYC
) (
  input wire REF_CLK,
  input wire RST_N,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WR,
  input wire REG_RD,
  output reg [7:0] REG_RDATA,
  input wire [5:0] DUTY_CMD,
  input wire [4:0] PWM_FREQ_SEL,
  input wire TACH_MODE_EN,
  input wire TACH_AT_MIN,
  output reg SPIN_ACTIVE,
  output reg [6:0] SPIN_PCT,
  output reg [5:0] DUTY_VALUE
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SPIN = 2'b10;

  reg [5:0] cfg_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [5:0] cmd_prev_r;
  reg fast_r;
  reg [6:0] pct_nxt;
  wire fast_en;
  wire [1:0] duty_sel;
  wire [2:0] time_sel;
  wire turn_on;
  wire bypass;
  wire start_spin;
  wire time_done;
  wire tach_stop;
  wire end_spin;

  assign fast_en = cfg_r[`FSS_FAST_BIT];
  assign duty_sel = cfg_r[`FSS_DUTY_HI:`FSS_DUTY_LO];
  assign time_sel = cfg_r[`FSS_TIME_HI:`FSS_TIME_LO];
  // (RL13) Off to on detect
  assign turn_on = (cmd_prev_r == 6'h00) && (DUTY_CMD != 6'h00);
  // (RL6) (RL7) Bypass conditions
  assign bypass = (time_sel == 3'h0) || ((duty_sel == `FSS_DUTY_OFF) && !fast_en);
  assign start_spin = state_r[0] && turn_on && !bypass;
  // (RL4) (RL10) Tach stop only in tach mode
  assign tach_stop = fast_r && TACH_MODE_EN && TACH_AT_MIN;
  assign end_spin = state_r[1] && (time_done || tach_stop);

  // (RL9) Interval timer
  fss_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .start(start_spin),
    .abort(end_spin),
    .time_code(time_sel),
    .done(time_done)
  );

  always @* begin
    case (state_r)
      ST_IDLE: state_nxt = start_spin ? ST_SPIN : ST_IDLE;
      ST_SPIN: state_nxt = end_spin ? ST_IDLE : ST_SPIN;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @* begin
    pct_nxt = `FSS_PCT_100;
    // (RL3) (RL5) Fast forces full duty
    if (!fast_en) begin
      // (RL2) (RL8) Programmed duty
      case (duty_sel)
        `FSS_DUTY_HALF: pct_nxt = `FSS_PCT_50;
        `FSS_DUTY_HIGH: pct_nxt = (PWM_FREQ_SEL < `FSS_FREQ_SPLIT) ? `FSS_PCT_81 : `FSS_PCT_75;
        `FSS_DUTY_FULL: pct_nxt = `FSS_PCT_100;
        default: pct_nxt = `FSS_PCT_ZERO;
      endcase
    end
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      // (RL11) Reset configuration
      cfg_r <= `FSS_START_CFG_RST;
      state_r <= ST_IDLE;
      cmd_prev_r <= 6'h00;
      fast_r <= 1'b0;
      REG_RDATA <= 8'h00;
      SPIN_ACTIVE <= 1'b0;
      SPIN_PCT <= `FSS_PCT_ZERO;
      DUTY_VALUE <= 6'h00;
    end else begin
      state_r <= state_nxt;
      cmd_prev_r <= DUTY_CMD;
      if (REG_WR && (REG_ADDR == `FSS_START_CFG_ADDR)) begin
        cfg_r <= REG_WDATA[5:0];
      end
      if (start_spin) begin
        fast_r <= fast_en;
        SPIN_PCT <= pct_nxt;
      end else if (end_spin) begin
        SPIN_PCT <= `FSS_PCT_ZERO;
      end
      SPIN_ACTIVE <= state_nxt[1];
      // Normal duty only outside spin-up
      DUTY_VALUE <= state_nxt[1] ? 6'h00 : DUTY_CMD;
      if (REG_RD) begin
        case (REG_ADDR)
          // (RL1) Upper bits zero
          `FSS_START_CFG_ADDR: REG_RDATA <= {2'h0, cfg_r};
          // (RL12) Zero during spin-up
          `FSS_DUTY_VAL_ADDR: REG_RDATA <= state_r[1] ? 8'h00 : {2'h0, DUTY_CMD};
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end
endmodule // fss_top
